// file: core/i2c_mbe_pkg.sv
// package for the two-wire master byte engine: register map, field positions, state types.
// assumes a single core clock; all pin levels are sampled, never used raw.
package i2c_mbe_pkg;
  localparam logic [2:0] OFS_XFER_BUFFER = 3'h0;
  localparam logic [2:0] OFS_CONTROL2 = 3'h1;
  localparam logic [2:0] OFS_STATUS = 3'h2;
  localparam logic [2:0] OFS_BAUD_RELOAD = 3'h3;
  localparam logic [2:0] OFS_FLAGS = 3'h4;
  // port_control2_reg fields
  localparam int CTL_STOP_EN = 2;
  localparam int CTL_RCV_EN = 3;
  localparam int CTL_ACK_SEQ = 4;
  localparam int CTL_ACK_DATA = 5;
  localparam int CTL_ACK_STAT = 6;
  // port_status_reg fields
  localparam int STS_BUF_FULL = 0;
  localparam int STS_START_DET = 3;
  localparam int STS_STOP_DET = 4;
  // flag/enable register fields; flags clear by writing 0
  localparam int FLG_IRQ = 0;
  localparam int FLG_WRITE_COLLISION_FLAG = 1;
  localparam int FLG_OVF = 2;
  localparam int FLG_BCOL = 3;
  localparam int FLG_IRQ_EN = 6;
  localparam int FLG_PORT_EN = 7;
  localparam logic [6:0] RST_BAUD_RELOAD = 7'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // core cycles per baud decrement (two decrements per instruction cycle)
  localparam int DECR_DIV = 2;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_LOW = 3'b001, ST_REL = 3'b011, ST_HIGH = 3'b010,
    ST_STOP_LOW = 3'b110, ST_STOP_REL = 3'b111, ST_STOP_HIGH = 3'b101, ST_STOP_END = 3'b100
  } state_t;
  typedef enum logic [1:0] {OP_TX = 2'b00, OP_RX = 2'b01, OP_ACK = 2'b11} op_t;

  typedef struct packed {
    logic scl, sda;
  } pins_t;

  typedef struct packed {
    state_t state;
    op_t op;
    logic [3:0] bitcnt;
    logic [7:0] shift_reg;
    logic [7:0] xfer_buffer;
    logic [6:0] baud_reload;
    logic [6:0] cnt;
    logic run;
    logic [1:0] div;
    pins_t meta, sync, prev;
    logic scl_rel, sda_rel;
    logic buffer_full_flag, rx_mode, start_det, stop_det;
    logic ack_data_bit, ack_status_bit, ack_sequence_enable;
    logic receive_enable_bit, stop_enable_bit;
    logic port_irq_flag, write_collision_flag, receive_overflow_flag, bus_collision_flag;
    logic irq_en, port_en, irq_out, wake;
    logic [7:0] rdata;
  } core_t;
endpackage

// file: core/i2c_master_byte_engine.sv
// master byte engine of a two-wire serial port: byte send with ack sampling,
// byte receive, ack sequence, stop sequence, clock stretching and bus-free tracking.
// assumes open-drain pins with external pull-ups and a one-cycle-read register port.
// Summary of operation
// [R01] buffer write sets full flag, starts baud
// [R02] bit: scl low one period, high one
// [R03] eighth falling edge clears full, releases sda
// [R04] slave pulls sda low to acknowledge
// [R05] ninth falling edge samples ack into status
// [R06] after ninth clock: irq, hold scl low
// [R07] write while busy sets collision, dropped
// [R08] receive enable ignored unless idle
// [R09] receive toggles scl per rollover, shifts sda
// [R10] eighth receive edge: store byte, flag, idle
// [R11] buffer read clears full flag in receive
// [R12] byte while full sets overflow flag
// [R13] ack sequence drives ack bit, one clock
// [R14] software sets ack bit before sequence
// [R15] stop: sda low, scl up, sda up
// [R16] stop seen sets detected; later irq
// [R17] released scl halts baud until high
// [R18] sleeping port wakes cpu on event
// [R19] reset disables port, aborts transfer
// [R20] start/stop detected clear on reset, disable
// [R21] bus stop raises irq while idle
// [R22] sda mismatch sets bus collision flag
// [R23] baud loads seven bits, counts to zero
//
// The placing of the registers and the strobed register port were left to the implementer.
module i2c_master_byte_engine
  import i2c_mbe_pkg::*;
#(
  parameter int DIV = DECR_DIV
) (
  input wire logic ref_clk_i, // core clock, 250 MHz
  input wire logic nrst_i, // async reset, active low
  input wire logic [2:0] addr_i, // register index
  input wire logic [7:0] wdata_i, // write data
  input wire logic wr_i, // write strobe
  input wire logic rd_i, // read strobe
  output logic [7:0] rdata_o, // read data, cycle after strobe
  input wire logic scl_i, // clock line level
  input wire logic sda_i, // data line level
  output logic scl_o, // clock line drive value
  output logic scl_oe_n_o, // clock line pulled low when 0
  output logic sda_o, // data line drive value
  output logic sda_oe_n_o, // data line pulled low when 0
  input wire logic sleep_i, // processor asleep
  output logic port_irq_o, // port interrupt request
  output logic wake_o // wake request while asleep
);
  core_t r_r, r_nxt;
  logic bto, tick, stop_ev, start_ev, busy, mismatch;

  assign bto = r_r.run && (r_r.cnt == 7'h00);
  assign tick = (r_r.div == 2'h0);
  assign stop_ev = r_r.sync.scl && r_r.prev.scl && r_r.sync.sda && !r_r.prev.sda;
  assign start_ev = r_r.sync.scl && r_r.prev.scl && !r_r.sync.sda && r_r.prev.sda;
  assign busy = (r_r.state != ST_IDLE);
  // a released sda that reads low while scl is high means another master drives 0
  assign mismatch = r_r.sda_rel && !r_r.sync.sda && r_r.op != OP_RX
    && !(r_r.op == OP_TX && r_r.bitcnt == BIT_ACK);

  always_comb begin
    r_nxt = r_r;
    r_nxt.meta = '{scl: scl_i, sda: sda_i};
    r_nxt.sync = r_r.meta;
    r_nxt.prev = r_r.sync;
    r_nxt.rdata = RST_BYTE;
    r_nxt.div = (r_r.div == 2'(DIV - 1)) ? 2'h0 : r_r.div + 2'h1;
    if (r_r.run && r_r.cnt != 7'h00 && tick) begin
      r_nxt.cnt = r_r.cnt - 7'h01; // see [R23]
    end
    // software side: reads, flag clears, configuration
    if (rd_i) begin
      unique case (addr_i)
        OFS_XFER_BUFFER: begin
          r_nxt.rdata = r_r.xfer_buffer;
          if (r_r.rx_mode) begin
            r_nxt.buffer_full_flag = 1'b0; // see [R11]
          end
        end
        OFS_CONTROL2: r_nxt.rdata = {1'b0, r_r.ack_status_bit, r_r.ack_data_bit,
          r_r.ack_sequence_enable, r_r.receive_enable_bit, r_r.stop_enable_bit, 2'b00};
        OFS_STATUS: r_nxt.rdata = {3'b000, r_r.stop_det, r_r.start_det, 2'b00,
          r_r.buffer_full_flag};
        OFS_BAUD_RELOAD: r_nxt.rdata = {1'b0, r_r.baud_reload};
        OFS_FLAGS: r_nxt.rdata = {r_r.port_en, r_r.irq_en, 2'b00, r_r.bus_collision_flag,
          r_r.receive_overflow_flag, r_r.write_collision_flag, r_r.port_irq_flag};
        default: r_nxt.rdata = RST_BYTE;
      endcase
    end
    if (wr_i && addr_i == OFS_BAUD_RELOAD) begin
      r_nxt.baud_reload = wdata_i[6:0];
    end
    if (wr_i && addr_i == OFS_FLAGS) begin
      // flags only clear here; hardware sets below win in the same cycle
      r_nxt.port_irq_flag = r_r.port_irq_flag & wdata_i[FLG_IRQ];
      r_nxt.write_collision_flag = r_r.write_collision_flag & wdata_i[FLG_WRITE_COLLISION_FLAG]; // see [R07]
      r_nxt.receive_overflow_flag = r_r.receive_overflow_flag & wdata_i[FLG_OVF];
      r_nxt.bus_collision_flag = r_r.bus_collision_flag & wdata_i[FLG_BCOL];
      r_nxt.irq_en = wdata_i[FLG_IRQ_EN];
      r_nxt.port_en = wdata_i[FLG_PORT_EN];
    end
    if (wr_i && addr_i == OFS_CONTROL2) begin
      r_nxt.ack_data_bit = wdata_i[CTL_ACK_DATA]; // see [R14]
    end
    // bus-free tracking
    if (start_ev) begin
      r_nxt.start_det = 1'b1;
      r_nxt.stop_det = 1'b0;
    end
    if (stop_ev) begin
      r_nxt.stop_det = 1'b1; // see [R16]
      r_nxt.start_det = 1'b0;
      if (!busy) begin
        r_nxt.port_irq_flag = 1'b1; // see [R21]
      end
    end
    unique case (r_r.state)
      ST_IDLE: ;
      ST_LOW: begin
        if (bto) begin
          r_nxt.scl_rel = 1'b1; // see [R02]
          r_nxt.run = 1'b0;
          r_nxt.state = ST_REL;
        end
      end
      ST_REL: begin
        if (r_r.sync.scl) begin
          r_nxt.cnt = r_r.baud_reload; // see [R17]
          r_nxt.run = 1'b1;
          r_nxt.state = ST_HIGH;
        end
      end
      ST_HIGH: begin
        if (mismatch) begin
          r_nxt.bus_collision_flag = 1'b1; // see [R22]
          r_nxt.state = ST_IDLE;
          r_nxt.run = 1'b0;
          r_nxt.scl_rel = 1'b1;
          r_nxt.sda_rel = 1'b1;
          r_nxt.buffer_full_flag = 1'b0;
          r_nxt.ack_sequence_enable = 1'b0;
        end else if (bto) begin
          r_nxt.scl_rel = 1'b0;
          r_nxt.cnt = r_r.baud_reload;
          r_nxt.bitcnt = r_r.bitcnt + 4'h1;
          r_nxt.state = ST_LOW;
          unique case (r_r.op)
            OP_TX: begin
              r_nxt.shift_reg = {r_r.shift_reg[6:0], 1'b0};
              r_nxt.sda_rel = (r_r.bitcnt == BIT_LAST) ? 1'b1 : r_r.shift_reg[6]; // see [R02]
              if (r_r.bitcnt == BIT_LAST) begin
                r_nxt.buffer_full_flag = 1'b0; // see [R01] [R03]
              end
              if (r_r.bitcnt == BIT_ACK) begin
                r_nxt.ack_status_bit = r_r.sync.sda; // see [R05]
                r_nxt.port_irq_flag = 1'b1; // see [R06]
                r_nxt.sda_rel = 1'b1;
                r_nxt.run = 1'b0;
                r_nxt.state = ST_IDLE;
              end
            end
            OP_RX: begin
              r_nxt.shift_reg = {r_r.shift_reg[6:0], r_r.sync.sda}; // see [R09]
              if (r_r.bitcnt == BIT_LAST) begin
                r_nxt.receive_enable_bit = 1'b0; // see [R10]
                r_nxt.xfer_buffer = {r_r.shift_reg[6:0], r_r.sync.sda};
                r_nxt.receive_overflow_flag = r_r.receive_overflow_flag
                  | r_r.buffer_full_flag; // see [R12]
                r_nxt.buffer_full_flag = 1'b1;
                r_nxt.port_irq_flag = 1'b1;
                r_nxt.rx_mode = 1'b1;
                r_nxt.run = 1'b0;
                r_nxt.state = ST_IDLE;
              end
            end
            default: begin
              r_nxt.ack_sequence_enable = 1'b0; // see [R13]
              r_nxt.sda_rel = 1'b1;
              r_nxt.run = 1'b0;
              r_nxt.state = ST_IDLE;
            end
          endcase
        end
      end
      ST_STOP_LOW: begin
        if (!r_r.sync.sda && !r_r.run) begin
          r_nxt.cnt = r_r.baud_reload; // see [R15]
          r_nxt.run = 1'b1;
        end
        if (bto) begin
          r_nxt.scl_rel = 1'b1;
          r_nxt.run = 1'b0;
          r_nxt.state = ST_STOP_REL;
        end
      end
      ST_STOP_REL: begin
        if (r_r.sync.scl) begin
          r_nxt.cnt = r_r.baud_reload; // see [R17]
          r_nxt.run = 1'b1;
          r_nxt.state = ST_STOP_HIGH;
        end
      end
      ST_STOP_HIGH: begin
        if (bto) begin
          r_nxt.sda_rel = 1'b1; // see [R15]
          r_nxt.run = 1'b0;
          r_nxt.state = ST_STOP_END;
        end
      end
      ST_STOP_END: begin
        if (r_r.stop_det && !r_r.run) begin
          r_nxt.cnt = r_r.baud_reload;
          r_nxt.run = 1'b1;
        end
        if (bto) begin
          r_nxt.stop_enable_bit = 1'b0; // see [R16]
          r_nxt.port_irq_flag = 1'b1;
          r_nxt.run = 1'b0;
          r_nxt.state = ST_IDLE;
        end
      end
      default: r_nxt.state = ST_IDLE;
    endcase
    // commands: only an idle, enabled port accepts them; no queueing
    if (wr_i && addr_i == OFS_XFER_BUFFER) begin
      if (busy || !r_r.port_en) begin
        r_nxt.write_collision_flag = 1'b1; // see [R07]
      end else begin
        r_nxt.xfer_buffer = wdata_i;
        r_nxt.shift_reg = wdata_i;
        r_nxt.buffer_full_flag = 1'b1; // see [R01]
        r_nxt.rx_mode = 1'b0;
        r_nxt.op = OP_TX;
        r_nxt.bitcnt = 4'h0;
        r_nxt.sda_rel = wdata_i[7];
        r_nxt.scl_rel = 1'b0;
        r_nxt.cnt = r_r.baud_reload;
        r_nxt.run = 1'b1;
        r_nxt.state = ST_LOW;
      end
    end
    if (wr_i && addr_i == OFS_CONTROL2 && !busy && r_r.port_en) begin
      r_nxt.scl_rel = 1'b0;
      r_nxt.bitcnt = 4'h0;
      r_nxt.cnt = r_r.baud_reload;
      r_nxt.run = 1'b1;
      if (wdata_i[CTL_ACK_SEQ]) begin
        r_nxt.ack_sequence_enable = 1'b1; // see [R13]
        r_nxt.op = OP_ACK;
        r_nxt.sda_rel = wdata_i[CTL_ACK_DATA];
        r_nxt.state = ST_LOW;
      end else if (wdata_i[CTL_RCV_EN]) begin
        r_nxt.receive_enable_bit = 1'b1; // see [R08]
        r_nxt.op = OP_RX;
        r_nxt.sda_rel = 1'b1;
        r_nxt.state = ST_LOW;
      end else if (wdata_i[CTL_STOP_EN]) begin
        r_nxt.stop_enable_bit = 1'b1; // see [R15]
        r_nxt.sda_rel = 1'b0;
        r_nxt.run = 1'b0;
        r_nxt.state = ST_STOP_LOW;
      end else begin
        r_nxt.scl_rel = r_r.scl_rel;
        r_nxt.run = r_r.run;
      end
    end
    if (!r_r.port_en) begin
      r_nxt.state = ST_IDLE; // see [R19]
      r_nxt.run = 1'b0;
      r_nxt.scl_rel = 1'b1;
      r_nxt.sda_rel = 1'b1;
      r_nxt.start_det = 1'b0; // see [R20]
      r_nxt.stop_det = 1'b0;
      r_nxt.ack_sequence_enable = 1'b0;
      r_nxt.receive_enable_bit = 1'b0;
      r_nxt.stop_enable_bit = 1'b0;
    end
    r_nxt.irq_out = r_nxt.port_irq_flag && r_nxt.irq_en;
    r_nxt.wake = r_nxt.irq_out && sleep_i; // see [R18]
  end

  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_r <= '0; // see [R19] [R20]
      r_r.baud_reload <= RST_BAUD_RELOAD;
      r_r.scl_rel <= 1'b1;
      r_r.sda_rel <= 1'b1;
      r_r.meta <= '{scl: 1'b1, sda: 1'b1};
      r_r.sync <= '{scl: 1'b1, sda: 1'b1};
      r_r.prev <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      r_r <= r_nxt;
    end
  end

  assign rdata_o = r_r.rdata;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_n_o = r_r.scl_rel;
  assign sda_oe_n_o = r_r.sda_rel;
  assign port_irq_o = r_r.irq_out;
  assign wake_o = r_r.wake;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  buf_write_full_a: assert property ( // see [R01]
    wr_i && addr_i == OFS_XFER_BUFFER && !busy && r_r.port_en
    |=> r_r.buffer_full_flag && r_r.state == ST_LOW && !r_r.scl_rel)
    else $error("buffer write did not start a byte");
  busy_write_write_collision_flag_a: assert property ( // see [R07]
    wr_i && addr_i == OFS_XFER_BUFFER && busy |=> r_r.write_collision_flag
    && $stable(r_r.xfer_buffer))
    else $error("write during transfer not refused");
  ack_sample_a: assert property ( // see [R05]
    r_r.state == ST_HIGH && r_r.op == OP_TX && r_r.bitcnt == BIT_ACK && bto && !mismatch
    |=> r_r.ack_status_bit == $past(r_r.sync.sda) && r_r.port_irq_flag
    && !r_r.scl_rel && r_r.state == ST_IDLE)
    else $error("ack not sampled at ninth falling edge");
  eighth_edge_a: assert property ( // see [R03]
    r_r.state == ST_HIGH && r_r.op == OP_TX && r_r.bitcnt == BIT_LAST && bto && !mismatch
    && !(wr_i && addr_i == OFS_XFER_BUFFER)
    |=> !r_r.buffer_full_flag && r_r.sda_rel)
    else $error("sda not released after eighth bit");
  rx_done_a: assert property ( // see [R10] [R12]
    r_r.state == ST_HIGH && r_r.op == OP_RX && r_r.bitcnt == BIT_LAST && bto && r_r.port_en
    |=> r_r.buffer_full_flag && r_r.port_irq_flag && !r_r.receive_enable_bit
    && r_r.receive_overflow_flag == ($past(r_r.buffer_full_flag)
    || $past(r_r.receive_overflow_flag)))
    else $error("receive completion wrong");
  rcv_ignored_a: assert property ( // see [R08]
    wr_i && addr_i == OFS_CONTROL2 && busy && !r_r.receive_enable_bit
    |=> !r_r.receive_enable_bit)
    else $error("receive enable taken while busy");
  released_hold_a: assert property ( // see [R17]
    r_r.state == ST_REL && !r_r.sync.scl && r_r.port_en |=> r_r.state == ST_REL
    && !r_r.run && r_r.scl_rel)
    else $error("baud ran while scl held low");
  stop_end_a: assert property ( // see [R16]
    r_r.state == ST_STOP_END && bto && r_r.port_en
    |=> !r_r.stop_enable_bit && r_r.port_irq_flag && r_r.state == ST_IDLE)
    else $error("stop did not finish");
  collision_a: assert property ( // see [R22]
    r_r.state == ST_HIGH && mismatch && r_r.port_en
    |=> r_r.bus_collision_flag && r_r.state == ST_IDLE
    && r_r.scl_rel && r_r.sda_rel)
    else $error("arbitration loss not flagged");
  // in ST_HIGH only a collision or a disable may move the data line before the clock falls
  high_hold_a: assert property ( // see [R02]
    r_r.state == ST_HIGH && !bto && !mismatch && r_r.port_en
    |=> $stable(r_r.sda_rel) && r_r.scl_rel)
    else $error("data line moved while clock high");
  baud_count_a: assert property ( // see [R23]
    r_r.state == ST_LOW && r_r.run && r_r.cnt != 7'h00 && tick
    |=> r_r.cnt == $past(r_r.cnt) - 7'h01)
    else $error("baud count did not step down");
  ack_seq_a: assert property ( // see [R13]
    r_r.state == ST_HIGH && r_r.op == OP_ACK && bto && !mismatch && r_r.port_en
    |=> !r_r.ack_sequence_enable && !r_r.scl_rel && r_r.state == ST_IDLE)
    else $error("ack sequence did not finish");
  stop_rise_a: assert property ( // see [R15]
    r_r.state == ST_STOP_HIGH && bto && r_r.port_en
    |=> r_r.sda_rel && r_r.state == ST_STOP_END)
    else $error("data line not released in stop");
  bus_stop_a: assert property ( // see [R21]
    stop_ev && !busy && r_r.port_en |=> r_r.port_irq_flag && r_r.stop_det)
    else $error("stop on free bus not flagged");
  port_off_a: assert property ( // see [R19] [R20]
    !r_r.port_en |=> r_r.state == ST_IDLE && r_r.scl_rel && r_r.sda_rel
    && !r_r.start_det && !r_r.stop_det)
    else $error("disabled port not idle");

  tx_byte_c: cover property (r_r.state == ST_HIGH && r_r.op == OP_TX
    && r_r.bitcnt == BIT_ACK && bto);
  rx_byte_c: cover property (r_r.state == ST_HIGH && r_r.op == OP_RX
    && r_r.bitcnt == BIT_LAST && bto);
  stop_seq_c: cover property (r_r.state == ST_STOP_END && bto);
  ack_seq_c: cover property (r_r.state == ST_HIGH && r_r.op == OP_ACK && bto);
  stretch_c: cover property (r_r.state == ST_REL && !r_r.sync.scl [*4]);
endmodule

// file: testbench/i2c_slave_model.sv
// behavioural slave on the two-wire bus: acknowledges, sends a byte, stretches the clock.
// assumes open-drain lines with pull-ups resolved by the bench; arm_i restarts the bit count.
module i2c_slave_model (
  input wire logic scl_i, // clock line level
  input wire logic sda_i, // data line level
  input wire logic arm_i, // restart bit count, pulse
  input wire logic send_i, // 1: slave sends tx_byte_i
  input wire logic nack_i, // withhold acknowledge
  input wire logic clash_i, // pull data low from arm until the next clock fall
  input wire logic [7:0] tx_byte_i, // byte to send, msb first
  input wire logic [15:0] stretch_i, // clock hold in ns after each fall
  output logic scl_pull_o, // 1 pulls clock low
  output logic sda_pull_o, // 1 pulls data low
  output logic [8:0] got_o // levels seen at clock rises, newest in bit 0
);
  timeunit 1ns;
  timeprecision 100ps;
  int rises;
  initial begin
    rises = 0;
    scl_pull_o = 1'b0;
    sda_pull_o = 1'b0;
    got_o = '0;
  end
  always @(posedge arm_i) begin
    rises = 0;
    sda_pull_o = (send_i & ~tx_byte_i[7]) | clash_i;
  end
  always @(posedge scl_i) begin
    rises = rises + 1;
    got_o = {got_o[7:0], sda_i};
  end
  // counting rises, not falls, ignores the fall that starts a transfer from a free bus
  always @(negedge scl_i) begin
    if (send_i) sda_pull_o = (rises < 8) ? !tx_byte_i[3'(7 - rises)] : 1'b0;
    else sda_pull_o = (rises == 8) && !nack_i;
    if (stretch_i != 16'h0000) begin
      scl_pull_o = 1'b1;
      #(stretch_i);
      scl_pull_o = 1'b0;
    end
  end
endmodule

// file: testbench/i2c_master_byte_engine_test.sv
// self-checking bench for the master byte engine, with a slave model on the wires.
// assumes pull-ups on both lines and the register map of the package.
module i2c_master_byte_engine_test import i2c_mbe_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] ENA = (8'h01 << FLG_PORT_EN) | (8'h01 << FLG_IRQ_EN);
  typedef struct packed {
    logic rx;
    logic nack;
    logic [7:0] data;
  } row_t;
  row_t rows [4] = '{'{1'b0, 1'b1, 8'hA5}, '{1'b0, 1'b0, 8'h3C}, '{1'b1, 1'b0, 8'h96},
    '{1'b1, 1'b0, 8'h01}};
  logic ref_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic sleep_i = 1'b0;
  logic arm_p = 1'b0, send = 1'b0, nack = 1'b0, clash = 1'b0;
  logic [7:0] tx_byte = 8'h00;
  logic [15:0] stretch = 16'h0000;
  logic [7:0] rdata_o;
  logic scl_drv, sda_drv, scl_oe_n, sda_oe_n, port_irq_o, wake_o, scl_pull, sda_pull;
  logic [8:0] got;
  int errors = 0;
  int total_checks = 0;
  wire scl_w = (scl_oe_n ? 1'b1 : scl_drv) & ~scl_pull;
  wire sda_w = (sda_oe_n ? 1'b1 : sda_drv) & ~sda_pull;

  always #2 ref_clk_i = ~ref_clk_i;

  i2c_master_byte_engine dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .scl_i(scl_w),
    .sda_i(sda_w), .scl_o(scl_drv), .scl_oe_n_o(scl_oe_n), .sda_o(sda_drv),
    .sda_oe_n_o(sda_oe_n), .sleep_i(sleep_i), .port_irq_o(port_irq_o), .wake_o(wake_o));

  i2c_slave_model slave_u (.scl_i(scl_w), .sda_i(sda_w), .arm_i(arm_p), .send_i(send),
    .nack_i(nack), .clash_i(clash), .tx_byte_i(tx_byte), .stretch_i(stretch),
    .scl_pull_o(scl_pull), .sda_pull_o(sda_pull), .got_o(got));

  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask

  task automatic expect_reg(input string what, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(what, exp, v);
  endtask

  // polls until the masked bits equal want; a bound keeps a stuck design from hanging
  task automatic wait_reg(input string what, input logic [2:0] a, input logic [7:0] m,
    input logic [7:0] want);
    logic [7:0] v;
    int n;
    n = 0;
    rd(a, v);
    while ((v & m) !== want && n < 600) begin
      rd(a, v);
      n++;
    end
    chk(what, want, v & m);
  endtask

  task automatic wait_irq;
    int n;
    n = 0;
    while (port_irq_o !== 1'b1 && n < 3000) begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    chk("irq", 8'h01, {7'h00, port_irq_o});
  endtask

  task automatic arm(input logic s, input logic k, input logic [7:0] b);
    send <= s;
    nack <= k;
    tx_byte <= b;
    arm_p <= 1'b1;
    @(posedge ref_clk_i);
    arm_p <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    expect_reg("status reset", OFS_STATUS, 8'h00);
    expect_reg("flags reset", OFS_FLAGS, 8'h00);
    wr(OFS_BAUD_RELOAD, 8'h03);
    expect_reg("baud reload", OFS_BAUD_RELOAD, 8'h03);
    wr(OFS_FLAGS, ENA);
    foreach (rows[i]) begin
      arm(rows[i].rx, rows[i].nack, rows[i].data);
      if (rows[i].rx) begin
        wr(OFS_CONTROL2, 8'h01 << CTL_RCV_EN);
        wait_irq();
        expect_reg("rx full", OFS_STATUS, 8'h01 << STS_BUF_FULL);
        expect_reg("rx enable", OFS_CONTROL2, 8'h00);
        expect_reg("rx byte", OFS_XFER_BUFFER, rows[i].data);
        expect_reg("read clears full", OFS_STATUS, 8'h00);
      end else begin
        wr(OFS_XFER_BUFFER, rows[i].data);
        expect_reg("tx full", OFS_STATUS, 8'h01 << STS_BUF_FULL);
        wait_irq();
        expect_reg("tx full clear", OFS_STATUS, 8'h00);
        expect_reg("ack status", OFS_CONTROL2, 8'(rows[i].nack) << CTL_ACK_STAT);
        chk("wire byte", rows[i].data, got[8:1]);
        chk("clock held", 8'h00, {7'h00, scl_w});
      end
      wr(OFS_FLAGS, ENA);
      $display("row %0d done", i);
    end
    arm(1'b0, 1'b0, 8'h5A);
    wr(OFS_XFER_BUFFER, 8'h5A);
    wr(OFS_XFER_BUFFER, 8'hFF);
    wr(OFS_CONTROL2, 8'h01 << CTL_RCV_EN);
    wait_irq();
    chk("byte kept", 8'h5A, got[8:1]);
    expect_reg("collision flag", OFS_FLAGS, ENA | 8'h03);
    expect_reg("rx ignored", OFS_CONTROL2, 8'h00);
    wr(OFS_FLAGS, ENA);
    $display("busy writes done");
    sleep_i <= 1'b1;
    repeat (2) begin
      arm(1'b1, 1'b0, 8'hC3);
      wr(OFS_CONTROL2, 8'h01 << CTL_RCV_EN);
      wait_irq();
      @(posedge ref_clk_i);
      #1 chk("wake", 8'h01, {7'h00, wake_o});
      // writing 1 to the overflow bit keeps it, so the second byte's overflow survives
      wr(OFS_FLAGS, ENA | (8'h01 << FLG_OVF));
    end
    sleep_i <= 1'b0;
    expect_reg("overflow", OFS_FLAGS, ENA | (8'h01 << FLG_OVF));
    expect_reg("rx byte again", OFS_XFER_BUFFER, 8'hC3);
    wr(OFS_FLAGS, ENA);
    for (int b = 1; b >= 0; b--) begin
      arm(1'b0, 1'b1, 8'h00);
      wr(OFS_CONTROL2, (8'h01 << CTL_ACK_SEQ) | (8'(b) << CTL_ACK_DATA));
      wait_reg("ack seq end", OFS_CONTROL2, 8'h01 << CTL_ACK_SEQ, 8'h00);
      chk("ack level", 8'(b), {7'h00, got[0]});
      chk("ack clock low", 8'h00, {7'h00, scl_w});
    end
    $display("ack sequence done");
    wr(OFS_CONTROL2, 8'h01 << CTL_STOP_EN);
    wait_irq();
    expect_reg("stop seen", OFS_STATUS, 8'h01 << STS_STOP_DET);
    expect_reg("stop bit clear", OFS_CONTROL2, 8'h00);
    chk("lines free", 8'h03, {6'h00, scl_w, sda_w});
    wr(OFS_FLAGS, ENA);
    stretch <= 16'd200;
    arm(1'b0, 1'b0, 8'h81);
    wr(OFS_XFER_BUFFER, 8'h81);
    wait_irq();
    chk("stretched byte", 8'h81, got[8:1]);
    stretch <= 16'h0000;
    wr(OFS_FLAGS, ENA);
    clash <= 1'b1;
    arm(1'b0, 1'b1, 8'h00);
    wr(OFS_XFER_BUFFER, 8'hFF);
    wait_reg("bus collision", OFS_FLAGS, 8'h01 << FLG_BCOL, 8'h01 << FLG_BCOL);
    // stop seen stays set from the stop test: no start has happened since
    expect_reg("collision full", OFS_STATUS, 8'h01 << STS_STOP_DET);
    chk("released", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    clash <= 1'b0;
    arm(1'b0, 1'b1, 8'h00);
    // letting go of the data line with the clock high is a stop on an idle port
    wait_reg("bus stop irq", OFS_FLAGS, 8'h01 << FLG_IRQ, 8'h01 << FLG_IRQ);
    $display("stop, stretch and collision done");
    wr(OFS_FLAGS, ENA);
    wr(OFS_XFER_BUFFER, 8'h55);
    repeat (40) @(posedge ref_clk_i);
    nrst_i <= 1'b0;
    #1 chk("reset release", 8'h03, {6'h00, scl_oe_n, sda_oe_n});
    repeat (16) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    expect_reg("status after reset", OFS_STATUS, 8'h00);
    expect_reg("control after reset", OFS_CONTROL2, 8'h00);
    expect_reg("unmapped", 3'h5, 8'h00);
    wr(OFS_XFER_BUFFER, 8'h11);
    expect_reg("write disabled", OFS_FLAGS, 8'h01 << FLG_WRITE_COLLISION_FLAG);
    $display("reset cases done");
    finish_test();
  end

  // the whole sequence needs well under 15000 cycles
  initial begin
    #(40000 * 4);
    errors++;
    $display("BAD watchdog expected done seen hang");
    finish_test();
  end
endmodule
